// ==== src/smb_defines.svh ====
// Constants for the management-bus target port: address, register map, timing
`ifndef SMB_DEFINES_SVH
`define SMB_DEFINES_SVH

// ==========================================================
// Bus address and register map
`define SMB_DEV_ADDR 7'h4c
`define SMB_REG_CFG1 8'h00
`define SMB_CFG1_TODIS 5
`define SMB_CFG1_RST 8'h00

// ==========================================================
// Packet check generator x^8 + x^2 + x + 1
`define SMB_CRC_POLY 8'h07

// ==========================================================
// Byte slots of a transaction
`define SMB_BYTE_ADDR 3'h0
`define SMB_BYTE_PTR 3'h1
`define SMB_BYTE_DATA 3'h2
`define SMB_BYTE_PEC 3'h3

// ==========================================================
// Inactivity timeout
`define SMB_TIMEOUT_MS 32'h0000_0019
`define SMB_CLK_HZ 32'h0131_2d00
`define SMB_TIMEOUT_CYC (`SMB_TIMEOUT_MS * (`SMB_CLK_HZ / 32'h0000_03e8))

`endif

// ==== src/smb_pkg.sv ====
// Types shared by the management-bus target port
package smb_pkg;

   // ==========================================================
   // Byte-level sequencer states
   typedef enum logic [2:0] {
      SMB_IDLE,
      SMB_RX,
      SMB_TXACK,
      SMB_TX,
      SMB_RXACK,
      SMB_IGNORE
   } smb_state_t;

endpackage : smb_pkg

// ==== src/smb_sync2.sv ====
// Two-flop synchroniser for one pin that idles high
`timescale 1ns/1ps
`default_nettype none

module smb_sync2 (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);

   logic meta_q;

   // ==========================================================
   // Both stages reset high, the bus idle level
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta_q <= 1'b1;
         q_o <= 1'b1;
      end
      else
      begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end

endmodule : smb_sync2

`default_nettype wire

// ==== src/smb_slave_port.sv ====
// Management-bus target port: address match, pointer, config register, PEC, timeout
// Function
// - Target only; never starts a transfer
// - Timeout after 25 ms idle, enabled at reset
// - Config bit five set disables timeout
// - Check byte sent only on extra clocks
// - Check byte is CRC-8, poly x8+x2+x+1
// - Answer only address 1001100 (0x98/0x99)
// - Start then seven address bits, direction
// - Acknowledge own address by pulling SDA low
// - Direction zero writes, direction one reads
// - Nine clocks per byte; SDA moves low
// - Direction fixed until a new start
// - First written byte loads the pointer
// - Second written byte goes to pointed register
// - Writes one or two bytes; reads one
// - Read returns register at current pointer
// - Repeated start begins a new address byte
// - Send byte only sets the pointer
// - Write byte acknowledged at every byte but a bad check byte
// - Receive byte: one byte, NACK, stop
// - Pointer write, repeated start, then read
// - Timeout releases SDA, drops the transaction
`timescale 1ns/1ps
`default_nettype none
`include "smb_defines.svh"

module smb_slave_port #(
   parameter int TIMEOUT_CYC = `SMB_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic [7:0] cfg1_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   input wire logic [7:0] reg_rdata_i,
   output logic timeout_o,
   output logic pec_err_o
);

   localparam logic [19:0] TO_LIM = 20'(TIMEOUT_CYC - 1);

   smb_pkg::smb_state_t st_q;
   logic scl_s;
   logic sda_s;
   logic scl_p_q;
   logic sda_p_q;
   logic [3:0] cnt_q;
   logic [2:0] byte_q;
   logic [7:0] shreg_q;
   logic rw_q;
   logic sda_oe_q;
   logic go_q;
   logic [7:0] crc_q;
   logic [7:0] ptr_q;
   logic [7:0] cfg_q;
   logic [19:0] to_cnt_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic activity;
   logic byte_end;
   logic addr_hit;
   logic ack_ok;
   logic to_fire;
   logic [7:0] crc_upd;
   logic [7:0] rd_byte;
   logic rd_msb;

   // ==========================================================
   // Bitwise CRC-8, MSB first, no reflection
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++)
      begin
         r = r[7] ? ({r[6:0], 1'b0} ^ `SMB_CRC_POLY) : {r[6:0], 1'b0};
      end
      return r;
   endfunction : crc8

   // ==========================================================
   // Pin synchronisers; SCL is sampled, never used as a clock
   smb_sync2 u_sync_scl (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(scl_i),
      .q_o(scl_s)
   );

   smb_sync2 u_sync_sda (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(sda_i),
      .q_o(sda_s)
   );

   // Previous sampled levels for edge finding
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // ==========================================================
   // Bus conditions
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign activity = (scl_s ^ scl_p_q) | (sda_s ^ sda_p_q);

   // Byte decode; the ninth clock follows the eighth falling edge
   assign byte_end = (st_q == smb_pkg::SMB_RX) && scl_fall && (cnt_q == 4'h8);
   assign addr_hit = (shreg_q[7:1] == `SMB_DEV_ADDR);
   assign crc_upd = crc8(crc_q, shreg_q);
   assign rd_byte = (ptr_q == `SMB_REG_CFG1) ? cfg_q : reg_rdata_i;
   assign rd_msb = rd_byte[7];

   // Whether the byte just received earns an acknowledge
   always_comb
   begin
      ack_ok = 1'b0;
      if (byte_q == `SMB_BYTE_ADDR)
      begin
         ack_ok = addr_hit;
      end
      else if (!rw_q)
      begin
         unique case (byte_q)
            `SMB_BYTE_PTR: ack_ok = 1'b1;
            `SMB_BYTE_DATA: ack_ok = 1'b1;
            `SMB_BYTE_PEC: ack_ok = (crc_upd == 8'h00);
            default: ack_ok = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Byte sequencer. Stop and start win over any clock edge; a
   // repeated start simply reopens address decode.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= smb_pkg::SMB_IDLE;
         cnt_q <= 4'h0;
         byte_q <= 3'h0;
         shreg_q <= 8'h00;
         rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
         go_q <= 1'b0;
      end
      else if (to_fire || stop_det)
      begin
         st_q <= smb_pkg::SMB_IDLE;
         sda_oe_q <= 1'b0;
      end
      else if (start_det)
      begin
         st_q <= smb_pkg::SMB_RX;
         cnt_q <= 4'h0;
         byte_q <= 3'h0;
         sda_oe_q <= 1'b0;
      end
      else
      begin
         unique case (st_q)
            smb_pkg::SMB_IDLE, smb_pkg::SMB_IGNORE:
            begin
               sda_oe_q <= 1'b0;
            end
            smb_pkg::SMB_RX:
            begin
               if (scl_rise && cnt_q != 4'h8)
               begin
                  shreg_q <= {shreg_q[6:0], sda_s};
                  cnt_q <= cnt_q + 4'h1;
               end
               else if (byte_end)
               begin
                  byte_q <= byte_q + 3'h1;
                  if (byte_q == `SMB_BYTE_ADDR)
                  begin
                     rw_q <= shreg_q[0];
                  end
                  if (ack_ok)
                  begin
                     st_q <= smb_pkg::SMB_TXACK;
                     sda_oe_q <= 1'b1;
                  end
                  else
                  begin
                     st_q <= smb_pkg::SMB_IGNORE;
                  end
               end
            end
            smb_pkg::SMB_TXACK:
            begin
               if (scl_fall)
               begin
                  cnt_q <= 4'h0;
                  if (rw_q)
                  begin
                     shreg_q <= rd_byte;
                     sda_oe_q <= ~rd_msb;
                     st_q <= smb_pkg::SMB_TX;
                  end
                  else
                  begin
                     sda_oe_q <= 1'b0;
                     st_q <= smb_pkg::SMB_RX;
                  end
               end
            end
            smb_pkg::SMB_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_q == 4'h7)
                  begin
                     sda_oe_q <= 1'b0; // Master owns the ack slot
                     st_q <= smb_pkg::SMB_RXACK;
                  end
                  else
                  begin
                     shreg_q <= {shreg_q[6:0], 1'b0};
                     sda_oe_q <= ~shreg_q[6];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            smb_pkg::SMB_RXACK:
            begin
               if (scl_rise)
               begin
                  go_q <= ~sda_s && (byte_q == `SMB_BYTE_PTR);
               end
               else if (scl_fall)
               begin
                  cnt_q <= 4'h0;
                  if (go_q)
                  begin
                     shreg_q <= crc_q;
                     sda_oe_q <= ~crc_q[7];
                     byte_q <= `SMB_BYTE_DATA;
                     st_q <= smb_pkg::SMB_TX;
                  end
                  else
                  begin
                     st_q <= smb_pkg::SMB_IGNORE;
                  end
               end
            end
            default:
            begin
               st_q <= smb_pkg::SMB_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Packet check accumulator. It spans a repeated start, so a
   // read byte covers both address bytes, the pointer and data.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         crc_q <= 8'h00;
      end
      else if (start_det && st_q != smb_pkg::SMB_RX)
      begin
         crc_q <= 8'h00;
      end
      else if (byte_end)
      begin
         crc_q <= crc_upd;
      end
      else if (st_q == smb_pkg::SMB_TXACK && scl_fall && rw_q)
      begin
         crc_q <= crc8(crc_q, rd_byte);
      end
   end

   // ==========================================================
   // Pointer, config register and external register writes.
   // The pointer is never reset so later reads see the last one.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_q <= `SMB_CFG1_RST;
         reg_wr_o <= 1'b0;
         reg_wdata_o <= 8'h00;
         pec_err_o <= 1'b0;
      end
      else
      begin
         reg_wr_o <= 1'b0;
         pec_err_o <= 1'b0;
         if (byte_end && !rw_q && byte_q == `SMB_BYTE_DATA)
         begin
            if (ptr_q == `SMB_REG_CFG1)
            begin
               cfg_q <= shreg_q;
            end
            else
            begin
               reg_wdata_o <= shreg_q;
               reg_wr_o <= 1'b1;
            end
         end
         if (byte_end && !rw_q && byte_q == `SMB_BYTE_PEC && !ack_ok)
         begin
            pec_err_o <= 1'b1;
         end
      end
   end

   // Pointer holds through reset on purpose
   always_ff @(posedge clk_i)
   begin
      if (byte_end && !rw_q && byte_q == `SMB_BYTE_PTR)
      begin
         ptr_q <= shreg_q;
      end
   end

   // ==========================================================
   // Inactivity timeout; any pin edge restarts the count
   always_ff @(posedge clk_i)
   begin
      if (rst_i || st_q == smb_pkg::SMB_IDLE || activity)
      begin
         to_cnt_q <= 20'h0_0000;
      end
      else if (to_cnt_q != TO_LIM)
      begin
         to_cnt_q <= to_cnt_q + 20'h0_0001;
      end
   end

   assign to_fire = ~cfg_q[`SMB_CFG1_TODIS] && st_q != smb_pkg::SMB_IDLE
                    && to_cnt_q == TO_LIM && !activity;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         timeout_o <= 1'b0;
      end
      else
      begin
         timeout_o <= to_fire;
      end
   end

   // ==========================================================
   // Outputs; SDA is open drain so only the enable moves
   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_q;
   assign cfg1_o = cfg_q;
   assign reg_addr_o = ptr_q;

   // ==========================================================
   // Checks
   a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == smb_pkg::SMB_IDLE || st_q == smb_pkg::SMB_IGNORE) |-> !sda_oe_q)
      else $error("SDA driven while not addressed");

   a_ack_match: assert property (@(posedge clk_i) disable iff (rst_i)
      (byte_end && byte_q == `SMB_BYTE_ADDR && addr_hit)
      |=> sda_oe_q && st_q == smb_pkg::SMB_TXACK)
      else $error("Own address not acknowledged");

   a_addr_miss: assert property (@(posedge clk_i) disable iff (rst_i)
      (byte_end && byte_q == `SMB_BYTE_ADDR && !addr_hit)
      |=> !sda_oe_q && st_q == smb_pkg::SMB_IGNORE)
      else $error("Foreign address answered");

   a_start_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      start_det |=> st_q == smb_pkg::SMB_RX && cnt_q == 4'h0 && byte_q == 3'h0)
      else $error("Start did not reopen address decode");

   a_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_det |=> st_q == smb_pkg::SMB_IDLE ##1 !sda_oe_q)
      else $error("Stop did not end the transaction");

   a_ptr_load: assert property (@(posedge clk_i) disable iff (rst_i)
      (byte_end && !rw_q && byte_q == `SMB_BYTE_PTR) |=> ptr_q == $past(shreg_q))
      else $error("Pointer not loaded from first byte");

   a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (byte_end && !rw_q && byte_q == `SMB_BYTE_DATA && ptr_q == `SMB_REG_CFG1)
      |=> cfg_q == $past(shreg_q) && !reg_wr_o)
      else $error("Config write lost");

   a_ptr_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == smb_pkg::SMB_IDLE) |=> $stable(ptr_q))
      else $error("Pointer moved between transactions");

   a_tx_msb: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q == smb_pkg::SMB_TXACK && scl_fall && rw_q)
      |=> sda_oe_q == !$past(rd_msb) && st_q == smb_pkg::SMB_TX)
      else $error("Read data first bit wrong");

   a_to_release: assert property (@(posedge clk_i) disable iff (rst_i)
      to_fire |=> st_q == smb_pkg::SMB_IDLE && !sda_oe_q && timeout_o)
      else $error("Timeout did not release the bus");

   a_to_disable: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_q[`SMB_CFG1_TODIS] |-> !to_fire)
      else $error("Timeout fired while disabled");

   a_pec_bad: assert property (@(posedge clk_i) disable iff (rst_i)
      (byte_end && !rw_q && byte_q == `SMB_BYTE_PEC && crc_upd != 8'h00)
      |=> !sda_oe_q && pec_err_o)
      else $error("Bad check byte acknowledged");

endmodule : smb_slave_port

`default_nettype wire

// ==== testbench/smb_host_model.sv ====
// Behavioural bus master that drives the target port over SCL and SDA
`timescale 1ns/1ps
`default_nettype none

module smb_host_model (
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i
);
   // ==========================================================
   // Link timing
   // Low phase is long so the target's synchronised replies land well before SCL rises
   int lo_ns = 280;

   // Bus idles released, SCL high
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   // ==========================================================
   // Bit and byte slots
   // One clock from SCL low: data moves a quarter into the low phase, sampled mid-high
   task automatic bit_slot(input logic b, output logic s);
      #(lo_ns / 4);
      sda_pull_o = ~b;
      #(lo_ns - lo_ns / 4);
      scl_o = 1'b1;
      #60;
      s = sda_i;
      #60;
      scl_o = 1'b0;
   endtask : bit_slot

   // Eight address or data bits, most significant first
   task automatic wbits(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_slot(d[i], s);
   endtask : wbits

   // Eight bits from the target, then our acknowledge or not
   task automatic rbyte(output logic [7:0] d, input logic mack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_slot(1'b1, s);
         d[i] = s;
      end
      bit_slot(~mack, s);
   endtask : rbyte

   // Start or repeated start from either idle or SCL low
   task automatic start_c();
      #100 sda_pull_o = 1'b0;
      #100 scl_o = 1'b1;
      #200 sda_pull_o = 1'b1;
      #200 scl_o = 1'b0;
   endtask : start_c

   // Stop: SDA rises while SCL is high
   task automatic stop_c();
      #100 sda_pull_o = 1'b1;
      #100 scl_o = 1'b1;
      #200 sda_pull_o = 1'b0;
      #400;
   endtask : stop_c
endmodule : smb_host_model

`default_nettype wire

// ==== testbench/smb_slave_port_tb_top.sv ====
// Self-checking bench for the management-bus target port
`timescale 1ns/1ps
`default_nettype none
`include "smb_defines.svh"

module smb_slave_port_tb_top;
   // ==========================================================
   // Signals
   localparam int TO_CYC = 2000;
   localparam logic [7:0] WR = {`SMB_DEV_ADDR, 1'b0};
   localparam logic [7:0] RD = {`SMB_DEV_ADDR, 1'b1};
   logic clk_i, rst_i, scl, sda_pull, sda, sda_o, sda_oe_o, reg_wr_o, timeout_o, pec_err_o;
   logic [7:0] cfg1_o, reg_addr_o, reg_wdata_o, reg_rdata_i, key, wr_addr, wr_data, d, p, v, c;
   logic a;
   int errors, cmp_count, wr_cnt, pec_cnt, to_cnt, cyc, n;

   // Open-drain data line with pull-up; the port's data value is what it drives
   assign sda = (sda_oe_o ? sda_o : 1'b1) & ~sda_pull;

   smb_slave_port #(.TIMEOUT_CYC(TO_CYC)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .cfg1_o(cfg1_o), .reg_addr_o(reg_addr_o),
      .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o), .reg_rdata_i(reg_rdata_i),
      .timeout_o(timeout_o), .pec_err_o(pec_err_o));

   smb_host_model u_host (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda));

   // ==========================================================
   // Clock, external register file and pulse monitor
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // External registers answer with a keyed copy of their address
   always @(negedge clk_i)
      reg_rdata_i <= reg_addr_o ^ key;

   // One-cycle pulses are counted where they stand; also the hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (reg_wr_o)
      begin
         wr_cnt <= wr_cnt + 1;
         wr_addr <= reg_addr_o;
         wr_data <= reg_wdata_o;
      end
      if (pec_err_o)
         pec_cnt <= pec_cnt + 1;
      if (timeout_o)
         to_cnt <= to_cnt + 1;
      if (cyc == 60000)
      begin
         errors++;
         give_verdict();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] crc(input logic [7:0] c0, input logic [7:0] b);
      logic [7:0] r;
      r = c0 ^ b;
      for (int i = 0; i < 8; i++)
         r = r[7] ? ((r << 1) ^ `SMB_CRC_POLY) : (r << 1);
      return r;
   endfunction : crc

   // Send one byte and compare the acknowledge slot
   task automatic put(input logic [7:0] b, input logic [7:0] exp_ack);
      logic s;
      u_host.wbits(b);
      u_host.bit_slot(1'b1, s);
      check("ack", {7'h00, ~s}, exp_ack);
   endtask : put

   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] dat);
      u_host.start_c();
      put(WR, 8'h01);
      put(ptr, 8'h01);
      put(dat, 8'h01);
      u_host.stop_c();
   endtask : write_reg

   task automatic read_cur(output logic [7:0] dat);
      u_host.start_c();
      put(RD, 8'h01);
      u_host.rbyte(dat, 1'b0);
      u_host.stop_c();
   endtask : read_cur

   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      void'($urandom(32'hfadc));
      key = 8'($urandom);
      repeat (16) @(posedge clk_i);
      @(negedge clk_i) rst_i = 1'b0;
      repeat (8) @(negedge clk_i);
      check("cfg1 reset", cfg1_o, `SMB_CFG1_RST);
      check("sda idle", {7'h00, sda_oe_o}, 8'h00);
      // Foreign address stays unanswered
      u_host.start_c();
      put(WR ^ 8'h02, 8'h00);
      u_host.stop_c();
      // Random traffic, fast and slow masters mixed
      repeat (6)
      begin
         p = 8'h01 + 8'($urandom_range(0, 254));
         d = 8'($urandom);
         n = wr_cnt;
         write_reg(p, d);
         check("wr count", 8'(wr_cnt - n), 8'h01);
         check("wr addr", wr_addr, p);
         check("wr data", wr_data, d);
         read_cur(v);
         check("rd ext", v, p ^ key);
         write_reg(8'h00, d);
         check("cfg1", cfg1_o, d);
         read_cur(v);
         check("rd cfg1", v, d);
         u_host.lo_ns = ($urandom_range(0, 1) == 1) ? 1200 : 280;
      end
      u_host.lo_ns = 280;
      // Pointer set, repeated start, read; no register write
      n = wr_cnt;
      u_host.start_c();
      put(WR, 8'h01);
      put(8'h5c, 8'h01);
      u_host.start_c();
      put(RD, 8'h01);
      u_host.rbyte(v, 1'b0);
      u_host.stop_c();
      check("rd byte", v, 8'h5c ^ key);
      check("send only", 8'(wr_cnt - n), 8'h00);
      // Mid-run reset; the pointer must survive it
      @(negedge clk_i) rst_i = 1'b1;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (8) @(negedge clk_i);
      check("cfg1 reset again", cfg1_o, `SMB_CFG1_RST);
      check("sda idle again", {7'h00, sda_oe_o}, 8'h00);
      // Read with the extra check byte
      u_host.start_c();
      put(RD, 8'h01);
      u_host.rbyte(v, 1'b1);
      u_host.rbyte(c, 1'b0);
      u_host.stop_c();
      check("rd kept ptr", v, 8'h5c ^ key);
      check("rd pec", c, crc(crc(8'h00, RD), v));
      // Write with good then corrupted check byte
      d = 8'($urandom);
      c = crc(crc(crc(8'h00, WR), 8'h21), d);
      for (int k = 0; k < 2; k++)
      begin
         u_host.start_c();
         put(WR, 8'h01);
         put(8'h21, 8'h01);
         put(d, 8'h01);
         put(k == 0 ? c : ~c, k == 0 ? 8'h01 : 8'h00);
         put(8'h5a, 8'h00);
         u_host.stop_c();
         check("pec err", 8'(pec_cnt), 8'(k));
      end
      // Stall with the address acknowledge held
      write_reg(8'h00, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         u_host.start_c();
         u_host.wbits(WR);
         repeat (TO_CYC + 200) @(negedge clk_i);
         check("timeouts", 8'(to_cnt), 8'h01);
         check("sda held", {7'h00, sda_oe_o}, 8'(k));
         u_host.bit_slot(1'b1, a);
         u_host.stop_c();
         write_reg(8'h00, 8'h20);
      end
      give_verdict();
   end
endmodule : smb_slave_port_tb_top

`default_nettype wire
